// ---- mon_seq_params.svh ----
`ifndef MON_SEQ_PARAMS_SVH
`define MON_SEQ_PARAMS_SVH

// system clock rate
`define CLK_MHZ          100
// per-channel conversion times in microseconds
`define TEMP_CONV_US     125000
`define VOLT_CONV_US     62500
`define TEMP_CONV_CYC    (`TEMP_CONV_US * `CLK_MHZ)
`define VOLT_CONV_CYC    (`VOLT_CONV_US * `CLK_MHZ)
// idle step per conversion-rate unit, in microseconds
`define IDLE_STEP_US     62500
`define IDLE_STEP_CYC    (`IDLE_STEP_US * `CLK_MHZ)

// channel numbering in conversion order
`define CH_FIRST_TEMP    3'd0
`define CH_FIRST_VOLT    3'd3
`define CH_LAST          3'd6
`define CH_DONE          3'd7

// read index map on the link side
`define IDX_LOCAL_TEMP   8'h00
`define IDX_REM1_TEMP    8'h01
`define IDX_REM2_TEMP    8'h02
`define IDX_LOCAL_EXT    8'h03
`define IDX_REM1_EXT     8'h04
`define IDX_REM2_EXT     8'h05
`define IDX_VOLT0        8'h06
`define IDX_VOLT1        8'h07
`define IDX_VOLT2        8'h08
`define IDX_VOLT3        8'h09
`define IDX_STATUS       8'h0a
`define PTR_RESET        8'h00

`endif

// ---- mon_seq_pkg.sv ----
`default_nettype none
package mon_seq_pkg;
   typedef enum logic [2:0] {
      ST_SLEEP = 3'b001,
      ST_CONV  = 3'b010,
      ST_WAIT  = 3'b100
   } seq_state_t;

   // temp[0]=remote 1, temp[1]=remote 2, temp[2]=local die
   // volt[0..3] in conversion order after the temperatures
   typedef struct packed {
      logic [2:0][10:0] temp;
      logic [3:0][7:0]  volt;
      logic [2:0]       over;
      logic [2:0]       under;
   } results_t;

   typedef struct packed {
      logic [2:0][7:0] high;
      logic [2:0][7:0] low;
   } temp_limits_t;
endpackage
`default_nettype wire

// ---- monitor_conversion_sequencer.sv ----
// How it works
// - each cycle converts all enabled channels; results publish after the sequence
// - order: remote one, remote two, local, voltage input zero (channel three), then the last three
// - busy flag is high only while a sequence is converting
// - reads during conversion return the previous complete results
// - full-speed conversion, programmable idle delay between sequences
// - disabled temperature or voltage channels are skipped
// - temperature channel takes 125ms, voltage channel 62.5ms
// - temperature results kept at 11 bits, readable any time
// - each voltage result stored as unsigned 8-bit code
// - nominal voltage input yields about code 198 via front-end scaling
// - fresh temperature results are compared against over and under limits
// - standby when the pin is low or the halt bit is set
// - both standby sources act alike; data kept, link side stays alive
// - pin low overrides any software request to convert
// - standby during conversion aborts it without latching results
// - after an abort the previous readings stay unchanged and readable
// - status byte top bit shows whether the converter is busy
// - short reads use the index set by an earlier command byte
// - read index resets to zero, selecting the local temperature
`include "mon_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module monitor_conversion_sequencer #(
   parameter logic [31:0] TEMP_CYC = `TEMP_CONV_CYC,
   parameter logic [31:0] VOLT_CYC = `VOLT_CONV_CYC,
   parameter logic [31:0] IDLE_CYC = `IDLE_STEP_CYC
) (
   // system clock and reset
   input  wire logic                    clk_sys_in,
   input  wire logic                    rst_in,
   // standby and configuration
   input  wire logic                    standby_request_pin_n_in,
   input  wire logic                    halt_in,
   input  wire logic                    temp_enable_in,
   input  wire logic                    volt_enable_in,
   input  wire logic [3:0]              conv_rate_in,
   input  wire mon_seq_pkg::temp_limits_t limits_in,
   // converter
   input  wire logic [10:0]             adc_result_in,
   output logic                         adc_enable_out,
   output logic [2:0]                   adc_channel_out,
   // status and results
   output logic                         busy_out,
   output logic                         standby_out,
   output mon_seq_pkg::results_t        results_out,
   // host link side
   input  wire logic                    link_clk_in,
   input  wire logic                    link_cmd_valid_in,
   input  wire logic [7:0]              link_cmd_byte_in,
   output logic [7:0]                   link_rd_data_out
);
   import mon_seq_pkg::*;

   function automatic logic [2:0] first_enabled(input logic [2:0] ch,
                                                input logic t_en,
                                                input logic v_en);
      if (t_en && ch < `CH_FIRST_VOLT) begin
         return ch;
      end else if (v_en && ch < `CH_FIRST_VOLT) begin
         return `CH_FIRST_VOLT;
      end else if (v_en && ch <= `CH_LAST) begin
         return ch;
      end else begin
         return `CH_DONE;
      end
   endfunction

   function automatic logic [31:0] conv_len(input logic [2:0] ch);
      return (ch < `CH_FIRST_VOLT) ? TEMP_CYC - 32'h1 : VOLT_CYC - 32'h1;
   endfunction

   // system domain state
   seq_state_t       st_q, st_d;
   logic [2:0]       ch_q, ch_d;
   logic [31:0]      cnt_q, cnt_d;
   logic             capture, commit;
   logic             pin_meta_q, pin_sync_q;
   logic [2:0][10:0] pend_temp_q;
   logic [3:0][7:0]  pend_volt_q;
   results_t         results_q;
   logic             pub_tg_q;
   logic [2:0]       over_w, under_w;

   wire logic        standby  = ~pin_sync_q | halt_in;
   wire logic [2:0]  ch_start = first_enabled(`CH_FIRST_TEMP,
                                    temp_enable_in, volt_enable_in);
   wire logic [2:0]  ch_next  = first_enabled(ch_q + 3'h1,
                                    temp_enable_in, volt_enable_in);
   wire logic        cnt_zero = (cnt_q == 32'h0);
   wire logic        is_temp  = (ch_q < `CH_FIRST_VOLT);
   wire logic [1:0]  vidx     = 2'(ch_q - `CH_FIRST_VOLT);
   wire logic [31:0] idle_len = 32'(IDLE_CYC * {28'h0, conv_rate_in});

   always_ff @(posedge clk_sys_in) begin
      pin_meta_q <= standby_request_pin_n_in;
      pin_sync_q <= pin_meta_q;
   end

   always_comb begin
      st_d    = st_q;
      ch_d    = ch_q;
      cnt_d   = cnt_q;
      capture = 1'b0;
      commit  = 1'b0;
      case (st_q)
         ST_SLEEP: begin
            if (!standby) begin
               st_d  = ST_CONV;
               ch_d  = ch_start;
               cnt_d = conv_len(ch_start);
            end
         end
         ST_CONV: begin
            if (standby) begin
               st_d = ST_SLEEP;
            end else if (ch_q == `CH_DONE) begin
               commit = 1'b1;
               st_d   = ST_WAIT;
               cnt_d  = idle_len;
            end else if (cnt_zero) begin
               capture = 1'b1;
               ch_d    = ch_next;
               cnt_d   = conv_len(ch_next);
            end else begin
               cnt_d = cnt_q - 32'h1;
            end
         end
         ST_WAIT: begin
            if (standby) begin
               st_d = ST_SLEEP;
            end else if (cnt_zero) begin
               st_d  = ST_CONV;
               ch_d  = ch_start;
               cnt_d = conv_len(ch_start);
            end else begin
               cnt_d = cnt_q - 32'h1;
            end
         end
         default: begin
            st_d = ST_SLEEP;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         st_q  <= ST_SLEEP;
         ch_q  <= `CH_FIRST_TEMP;
         cnt_q <= 32'h0;
      end else begin
         st_q  <= st_d;
         ch_q  <= ch_d;
         cnt_q <= cnt_d;
      end
   end

   // per-channel staging, never visible until commit
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pend_temp_q <= '0;
         pend_volt_q <= '0;
      end else if (capture && is_temp) begin
         pend_temp_q[ch_q[1:0]] <= adc_result_in;
      end else if (capture) begin
         // front-end divider puts nominal inputs near code 198
         pend_volt_q[vidx] <= adc_result_in[7:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cmp
         assign over_w[gi]  = $signed(pend_temp_q[gi][10:3]) >
                              $signed(limits_in.high[gi]);
         assign under_w[gi] = $signed(pend_temp_q[gi][10:3]) <
                              $signed(limits_in.low[gi]);
      end
   endgenerate

   // published set changes only on a finished sequence
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         results_q <= '0;
         pub_tg_q  <= 1'b0;
      end else if (commit) begin
         results_q <= '{temp: pend_temp_q, volt: pend_volt_q,
                        over: over_w, under: under_w};
         pub_tg_q  <= ~pub_tg_q;
      end
   end

   assign busy_out        = (st_q == ST_CONV);
   assign adc_enable_out  = busy_out;
   assign adc_channel_out = ch_q;
   assign standby_out     = (st_q == ST_SLEEP);
   assign results_out     = results_q;

   // link domain
   logic       lrst_meta_q, lrst_q;
   logic       ptg_meta_q, ptg_sync_q, ptg_seen_q;
   logic       bsy_meta_q, bsy_sync_q;
   results_t   shadow_q;
   logic [7:0] ptr_q;
   logic [7:0] rd_data_q;
   logic [7:0] rd_mux;

   always_ff @(posedge link_clk_in) begin
      lrst_meta_q <= rst_in;
      lrst_q      <= lrst_meta_q;
      ptg_meta_q  <= pub_tg_q;
      ptg_sync_q  <= ptg_meta_q;
      bsy_meta_q  <= st_q[1]; // one-hot conv bit, a flop, no glitch
      bsy_sync_q  <= bsy_meta_q;
   end

   // results_q is stable for a whole sequence after each toggle
   always_ff @(posedge link_clk_in) begin
      if (lrst_q) begin
         ptg_seen_q <= 1'b0;
         shadow_q   <= '0;
      end else if (ptg_sync_q != ptg_seen_q) begin
         ptg_seen_q <= ptg_sync_q;
         shadow_q   <= results_q;
      end
   end

   // index only moves when a command byte arrives
   always_ff @(posedge link_clk_in) begin
      if (lrst_q) begin
         ptr_q <= `PTR_RESET;
      end else if (link_cmd_valid_in) begin
         ptr_q <= link_cmd_byte_in;
      end
   end

   always_comb begin
      case (ptr_q)
         `IDX_LOCAL_TEMP: rd_mux = shadow_q.temp[2][10:3];
         `IDX_REM1_TEMP:  rd_mux = shadow_q.temp[0][10:3];
         `IDX_REM2_TEMP:  rd_mux = shadow_q.temp[1][10:3];
         `IDX_LOCAL_EXT:  rd_mux = {shadow_q.temp[2][2:0], 5'h00};
         `IDX_REM1_EXT:   rd_mux = {shadow_q.temp[0][2:0], 5'h00};
         `IDX_REM2_EXT:   rd_mux = {shadow_q.temp[1][2:0], 5'h00};
         `IDX_VOLT0:      rd_mux = shadow_q.volt[0];
         `IDX_VOLT1:      rd_mux = shadow_q.volt[1];
         `IDX_VOLT2:      rd_mux = shadow_q.volt[2];
         `IDX_VOLT3:      rd_mux = shadow_q.volt[3];
         `IDX_STATUS:     rd_mux = {bsy_sync_q, shadow_q.over,
                                    shadow_q.under, 1'b0};
         default:         rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge link_clk_in) begin
      if (lrst_q) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_mux;
      end
   end

   assign link_rd_data_out = rd_data_q;

   a_commit_end: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $changed(pub_tg_q) |-> $past(st_q) == ST_CONV &&
                             $past(ch_q) == `CH_DONE)
      else $error("results published before sequence end");
   a_hold_prev: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$changed(pub_tg_q) |-> $stable(results_q))
      else $error("results changed without a commit");
   a_abort_clean: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (st_q == ST_CONV && standby) |=> st_q == ST_SLEEP ##1
                                         $stable(results_q))
      else $error("standby did not abort cleanly");
   a_standby_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      standby [*2] |-> !busy_out && !adc_enable_out)
      else $error("converting while in standby");
   a_skip_temp: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ($rose(busy_out) && !$past(temp_enable_in) && $past(volt_enable_in))
      |-> ch_q == `CH_FIRST_VOLT)
      else $error("disabled temperature channel not skipped");
   a_chan_order: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (st_q == ST_CONV && !standby && cnt_zero && ch_q != `CH_DONE)
      |=> ch_q > $past(ch_q))
      else $error("channel order went backward");
   a_conv_time: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (st_q == ST_CONV && $changed(ch_q) && ch_q != `CH_DONE)
      |-> cnt_q == conv_len(ch_q))
      else $error("wrong conversion length loaded");
   a_alarm_cmp: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      commit |=> results_q.over[0] == ($signed(results_q.temp[0][10:3]) >
                 $signed($past(limits_in.high[0]))))
      else $error("over-limit flag does not match result");
   a_idle_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (commit && !standby) |=> st_q == ST_WAIT &&
                               cnt_q == $past(idle_len))
      else $error("idle delay not loaded after sequence");
   a_restart: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (st_q == ST_WAIT && cnt_zero && !standby) |=> busy_out)
      else $error("next sequence did not start");
   a_ptr_reset: assert property (@(posedge link_clk_in)
      lrst_q |=> ptr_q == `PTR_RESET)
      else $error("read index not cleared by reset");
   a_busy_msb: assert property (@(posedge link_clk_in) disable iff (lrst_q)
      (ptr_q == `IDX_STATUS) |=> rd_data_q[7] == $past(bsy_sync_q))
      else $error("status top bit does not follow busy");
endmodule
`default_nettype wire

// ---- mon_seq_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module mon_seq_host (
   // link side
   input  wire logic       link_clk_in,
   output logic            link_cmd_valid_out,
   output logic [7:0]      link_cmd_byte_out
);
   initial begin
      link_cmd_valid_out = 1'b0;
      link_cmd_byte_out  = 8'h00;
   end

   // command byte selects the index used by later short reads
   task automatic send_cmd(input logic [7:0] b);
      @(posedge link_clk_in);
      link_cmd_valid_out <= 1'b1;
      link_cmd_byte_out  <= b;
      @(posedge link_clk_in);
      link_cmd_valid_out <= 1'b0;
      // released byte shows its inverse, not a stale copy
      link_cmd_byte_out  <= ~b;
      repeat (3) @(posedge link_clk_in);
   endtask
endmodule
`default_nettype wire

// ---- monitor_conversion_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module monitor_conversion_sequencer_bench;
   import mon_seq_pkg::*;
   localparam int TC = 200;
   localparam int VC = 100;
   localparam int IC = 50;
   logic         clk_sys_in, rst_in, link_clk_in, pin_n, halt, t_en, v_en;
   logic [3:0]   rate;
   temp_limits_t lim;
   logic [10:0]  adc;
   logic [7:0]   base, cb, rd;
   logic         adc_en, busy, sb, cv;
   logic [2:0]   ch;
   results_t     res, old;
   int           fails, n_checks;

   monitor_conversion_sequencer #(.TEMP_CYC(TC), .VOLT_CYC(VC),
      .IDLE_CYC(IC)) u_dut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .standby_request_pin_n_in(pin_n), .halt_in(halt),
      .temp_enable_in(t_en), .volt_enable_in(v_en),
      .conv_rate_in(rate), .limits_in(lim), .adc_result_in(adc),
      .adc_enable_out(adc_en), .adc_channel_out(ch), .busy_out(busy),
      .standby_out(sb), .results_out(res), .link_clk_in(link_clk_in),
      .link_cmd_valid_in(cv), .link_cmd_byte_in(cb),
      .link_rd_data_out(rd));
   mon_seq_host u_host (.link_clk_in(link_clk_in),
      .link_cmd_valid_out(cv), .link_cmd_byte_out(cb));

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      link_clk_in = 1'b0;
      #37;
      forever #80 link_clk_in = ~link_clk_in;
   end
   // converter answers with a code derived from channel and base
   always @(posedge clk_sys_in) begin
      adc <= (ch < 3'h3) ? {base + 8'(ch), ch} : {3'h0, base + 8'(ch)};
   end

   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 5000 && busy !== lvl; i++) @(negedge clk_sys_in);
      chk(busy, lvl);
   endtask

   task automatic run_seq(input logic [7:0] b, input logic te,
                          input logic ve, input int first, input int last);
      logic [2:0] prev;
      int         k;
      wait_busy(1'b0);
      @(posedge clk_sys_in);
      base <= b;
      t_en <= te;
      v_en <= ve;
      wait_busy(1'b1);
      old = res;
      k = first;
      prev = 3'h7;
      while (busy === 1'b1) begin
         if (ch !== prev && ch !== 3'h7) begin
            chk(ch, k[2:0]);
            chk(res, old);
            prev = ch;
            k++;
         end
         @(negedge clk_sys_in);
      end
      chk(k, last + 1);
      for (int i = first; i <= last; i++) begin
         if (i < 3) chk(res.temp[i], {b + 8'(i), 3'(i)});
         else chk(res.volt[i - 3], b + 8'(i));
      end
      $display("sequence %h done", b);
   endtask

   task automatic t_link(input logic [7:0] idx, input logic [7:0] exp);
      u_host.send_cmd(idx);
      @(negedge link_clk_in);
      chk(rd, exp);
   endtask

   task automatic t_idle(input logic [3:0] r);
      int gap;
      @(posedge clk_sys_in);
      rate <= r;
      wait_busy(1'b1);
      wait_busy(1'b0);
      gap = 0;
      while (busy !== 1'b1 && gap < 2000) begin
         @(negedge clk_sys_in);
         gap++;
      end
      chk(gap >= int'(r) * IC && gap <= int'(r) * IC + 2, 1'b1);
      $display("idle test rate %0d done", r);
   endtask

   task automatic t_standby(input int s);
      wait_busy(1'b0);
      wait_busy(1'b1);
      old = res;
      repeat (30) @(negedge clk_sys_in);
      @(posedge clk_sys_in);
      if (s == 1) halt <= 1'b1;
      else pin_n <= 1'b0;
      repeat (4) @(negedge clk_sys_in);
      chk({sb, busy, adc_en}, 3'b100);
      repeat (3 * TC) @(negedge clk_sys_in);
      chk(res, old);
      chk(sb, 1'b1);
      t_link(8'h06, old.volt[0]);
      u_host.send_cmd(8'h0a);
      @(negedge link_clk_in);
      chk(rd[7], 1'b0);
      @(posedge clk_sys_in);
      halt <= 1'b0;
      pin_n <= 1'b1;
      wait_busy(1'b1);
      $display("standby test %0d done", s);
   endtask

   task automatic t_por_index;
      repeat (6) @(negedge link_clk_in);
      chk(rd, 8'h12);
      $display("index reset test done");
   endtask

   task automatic t_busy_bit;
      wait_busy(1'b1);
      u_host.send_cmd(8'h0a);
      @(negedge link_clk_in);
      chk(rd[7], 1'b1);
      $display("busy bit test done");
   endtask

   initial begin
      rst_in = 1'b1;
      pin_n = 1'b1;
      halt = 1'b1;
      t_en = 1'b1;
      v_en = 1'b1;
      rate = 4'h1;
      base = 8'h10;
      fails = 0;
      n_checks = 0;
      lim = '{high: {3{8'h7f}}, low: {3{8'h80}}};
      // link reset is synced, so hold across several link edges
      repeat (60) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      halt <= 1'b0;
      run_seq(8'h10, 1'b1, 1'b1, 0, 6);
      t_por_index;
      @(posedge clk_sys_in);
      lim <= '{high: {8'h7f, 8'h21, 8'h1f}, low: {8'h23, 8'h21, 8'h80}};
      run_seq(8'h20, 1'b1, 1'b1, 0, 6);
      chk({res.over, res.under}, 6'b001100);
      t_link(8'h01, 8'h20);
      run_seq(8'h30, 1'b0, 1'b1, 3, 6);
      run_seq(8'h40, 1'b1, 1'b0, 0, 2);
      run_seq(8'h50, 1'b1, 1'b1, 0, 6);
      t_busy_bit;
      t_idle(4'h1);
      t_idle(4'h3);
      t_standby(0);
      t_standby(1);
      finish_test;
   end

   initial begin
      #300_000;
      fails++;
      finish_test;
   end
endmodule
`default_nettype wire
